// File: common/sllc_regs.svh
// Register offsets, field positions and reset values of the lane configuration bank
`ifndef SLLC_REGS_SVH
`define SLLC_REGS_SVH

// ==========================================================================
// Offsets
`define SLLC_ADDR_W 16
`define SLLC_OFF_FORMAT 16'h0592
`define SLLC_OFF_CKSUM0 16'h05a0
`define SLLC_OFF_CKSUM1 16'h05a1
`define SLLC_OFF_PWDN 16'h05b0
`define SLLC_OFF_MAP0 16'h05b2
`define SLLC_OFF_MAP1 16'h05b3
`define SLLC_OFF_SWING0 16'h05c0
`define SLLC_OFF_SWING1 16'h05c1

// ==========================================================================
// Fields
`define SLLC_HIGH_DENSITY_BIT 7
`define SLLC_CTRL_WORDS_MSB 4
`define SLLC_SEL_MSB 2
`define SLLC_PWDN_L0_BIT 0
`define SLLC_PWDN_L1_BIT 2
`define SLLC_PWDN_RSVD_MASK 8'hfa
`define SLLC_MAP_SEL_MASK 8'h07
`define SLLC_MAP_RSVD_MASK 8'h70
`define SLLC_SWING_MASK 8'h07

// ==========================================================================
// Reset values
`define SLLC_RST_FORMAT 8'h00
`define SLLC_RST_CKSUM0 8'hc3
`define SLLC_RST_CKSUM1 8'hc4
`define SLLC_RST_PWDN 8'hfa
`define SLLC_RST_MAP0 8'h00
`define SLLC_RST_MAP1 8'h11
`define SLLC_RST_SWING 8'h01
`define SLLC_ZERO_BYTE 8'h00

`endif

// File: common/sllc_pkg.sv
// Types shared by the lane configuration bank
package sllc_pkg;
  localparam int sllc_lanes = 2;

  // Link configuration parameters that feed the per-lane checksum
  typedef struct packed {
    logic [7:0] did;
    logic [3:0] bid;
    logic [4:0] l_m1;
    logic scr;
    logic [7:0] f_m1;
    logic [4:0] k_m1;
    logic [7:0] m_m1;
    logic [1:0] cs;
    logic [4:0] n_m1;
    logic [2:0] subclass;
    logic [4:0] np_m1;
    logic [2:0] jesdv;
    logic [4:0] s_m1;
    logic high_density_flag;
    logic [4:0] control_words_per_frame;
  } sllc_link_params_t;
endpackage

// File: common/sllc_cksum_if.sv
// Carrier between the register bank and one lane checksum unit
`timescale 1ns/10ps
interface sllc_cksum_if;
  sllc_pkg::sllc_link_params_t params;
  logic [4:0] lane_id;
  logic [7:0] checksum;

  modport bank (output params, output lane_id, input checksum);
  modport unit (input params, input lane_id, output checksum);
endinterface

// File: hdl/sllc_lane_checksum.sv
// Per-lane link configuration checksum, summed modulo 256
`timescale 1ns/10ps
`include "sllc_regs.svh"
module sllc_lane_checksum #(
  parameter logic [7:0] RESET_VAL = `SLLC_ZERO_BYTE
) (
  input wire logic clock,
  input wire logic rst,
  sllc_cksum_if.unit ck
);
  logic [7:0] sum_q;
  logic [7:0] sum_d;

  // ==========================================================================
  // Sum of every field; the 8-bit adder wraps, which is the modulo 256
  always_comb begin
    sum_d = 8'(ck.params.did) + 8'(ck.params.bid) + 8'(ck.lane_id)
          + 8'(ck.params.l_m1) + 8'(ck.params.scr) + ck.params.f_m1
          + 8'(ck.params.k_m1) + ck.params.m_m1 + 8'(ck.params.cs)
          + 8'(ck.params.n_m1) + 8'(ck.params.subclass) + 8'(ck.params.np_m1)
          + 8'(ck.params.jesdv) + 8'(ck.params.s_m1) + 8'(ck.params.high_density_flag)
          + 8'(ck.params.control_words_per_frame);
  end

  // Registered so the read path sees a stable value, never a rippling adder
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sum_q <= RESET_VAL;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign ck.checksum = sum_q;
endmodule // sllc_lane_checksum

// File: hdl/sllc_lane_config_regs.sv
// Register bank for serial link format status, lane checksums, power-down, mapping and swing
`timescale 1ns/10ps
`include "sllc_regs.svh"

// Summary of operation
// - Read-only high-density flag in format bit 7
// - Read-only control words per frame in bits 4:0
// - Lane checksum is parameter sum modulo 256
// - Lane 0 checksum register, default 0xc3
// - Lane 1 checksum register, default 0xc4
// - Power-down bit 0 forces lane zero off
// - Power-down bit 2 forces lane one off
// - Lane zero logical source from map field
// - Lane one logical source, resets to one
// - Per-lane three-bit swing code, reset one
module sllc_lane_config_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire sllc_pkg::sllc_link_params_t link_params,
  output logic physical_output_lane_zero_pwdn,
  output logic physical_output_lane_one_pwdn,
  output logic [2:0] physical_output_lane_zero_src,
  output logic [2:0] physical_output_lane_one_src,
  output logic [2:0] physical_output_lane_zero_swing,
  output logic [2:0] physical_output_lane_one_swing
);
  // ==========================================================================
  // Address decode, shared by the write and read paths
  function automatic logic sllc_hit(input logic [15:0] addr, input logic [15:0] off);
    sllc_hit = (addr == off);
  endfunction

  // ==========================================================================
  // Storage
  // Format status, a registered copy of the live link settings
  logic [7:0] format_q;
  logic [7:0] format_d;

  // Lane power-down; reserved bits are kept exactly as written
  logic [7:0] pwdn_q;
  logic [7:0] pwdn_d;

  // Lane mapping, one register per physical lane
  logic [7:0] map0_q;
  logic [7:0] map0_d;
  logic [7:0] map1_q;
  logic [7:0] map1_d;

  // Swing codes, one register per physical lane
  logic [7:0] swing0_q;
  logic [7:0] swing0_d;
  logic [7:0] swing1_q;
  logic [7:0] swing1_d;

  // Read data register and the checksum bytes it can select
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] cksum [sllc_pkg::sllc_lanes];

  // ==========================================================================
  // Checksum units, one per physical lane
  sllc_cksum_if ck_if [sllc_pkg::sllc_lanes] ();

  generate
    for (genvar g = 0; g < sllc_pkg::sllc_lanes; g++) begin : g_lane
      localparam logic [7:0] CK_RST = (g == 0) ? `SLLC_RST_CKSUM0 : `SLLC_RST_CKSUM1;
      // Lane id follows the logical lane the physical lane carries
      assign ck_if[g].params = link_params;
      assign ck_if[g].lane_id = (g == 0) ? 5'(map0_q[`SLLC_SEL_MSB:0])
                                         : 5'(map1_q[`SLLC_SEL_MSB:0]);
      assign cksum[g] = ck_if[g].checksum;
      sllc_lane_checksum #(
        .RESET_VAL(CK_RST)
      ) u_cksum (
        .clock(clock),
        .rst(rst),
        .ck(ck_if[g].unit)
      );
    end
  endgenerate

  // ==========================================================================
  // Format status mirrors the link's live format; software cannot write it
  always_comb begin
    format_d = `SLLC_ZERO_BYTE;
    format_d[`SLLC_HIGH_DENSITY_BIT] = link_params.high_density_flag;
    format_d[`SLLC_CTRL_WORDS_MSB:0] = link_params.control_words_per_frame;
  end

  // ==========================================================================
  // Write strobes, one per writable offset; read-only offsets get none at all
  logic wr_pwdn;
  logic wr_map0;
  logic wr_map1;
  logic wr_swing0;
  logic wr_swing1;

  assign wr_pwdn = reg_wr && sllc_hit(reg_addr, `SLLC_OFF_PWDN);
  assign wr_map0 = reg_wr && sllc_hit(reg_addr, `SLLC_OFF_MAP0);
  assign wr_map1 = reg_wr && sllc_hit(reg_addr, `SLLC_OFF_MAP1);
  assign wr_swing0 = reg_wr && sllc_hit(reg_addr, `SLLC_OFF_SWING0);
  assign wr_swing1 = reg_wr && sllc_hit(reg_addr, `SLLC_OFF_SWING1);

  // ==========================================================================
  // Writable registers; read-only bits are masked so writes cannot disturb them
  always_comb begin
    pwdn_d = pwdn_q;
    map0_d = map0_q;
    map1_d = map1_q;
    swing0_d = swing0_q;
    swing1_d = swing1_q;
    // Reserved writable bits are stored as written; the host must preserve them
    if (wr_pwdn) begin
      pwdn_d = reg_wdata;
    end
    if (wr_map0) begin
      map0_d = reg_wdata & (`SLLC_MAP_SEL_MASK | `SLLC_MAP_RSVD_MASK);
    end
    if (wr_map1) begin
      map1_d = reg_wdata & (`SLLC_MAP_SEL_MASK | `SLLC_MAP_RSVD_MASK);
    end
    if (wr_swing0) begin
      swing0_d = reg_wdata & `SLLC_SWING_MASK;
    end
    if (wr_swing1) begin
      swing1_d = reg_wdata & `SLLC_SWING_MASK;
    end
  end

  // ==========================================================================
  // Read mux, registered; unmapped offsets read as zero
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      // Offsets are distinct, so at most one match below replaces the zero
      rdata_d = `SLLC_ZERO_BYTE;
      if (sllc_hit(reg_addr, `SLLC_OFF_FORMAT)) begin
        rdata_d = format_q;
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_CKSUM0)) begin
        rdata_d = cksum[0];
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_CKSUM1)) begin
        rdata_d = cksum[1];
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_PWDN)) begin
        rdata_d = pwdn_q;
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_MAP0)) begin
        rdata_d = map0_q;
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_MAP1)) begin
        rdata_d = map1_q;
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_SWING0)) begin
        rdata_d = swing0_q;
      end
      if (sllc_hit(reg_addr, `SLLC_OFF_SWING1)) begin
        rdata_d = swing1_q;
      end
    end
  end

  // ==========================================================================
  // Format status register; one cycle behind the live link settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      format_q <= `SLLC_RST_FORMAT;
    end else begin
      format_q <= format_d;
    end
  end

  // ==========================================================================
  // Host-writable control registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwdn_q <= `SLLC_RST_PWDN;
      map0_q <= `SLLC_RST_MAP0;
      map1_q <= `SLLC_RST_MAP1;
      swing0_q <= `SLLC_RST_SWING;
      swing1_q <= `SLLC_RST_SWING;
    end else begin
      pwdn_q <= pwdn_d;
      map0_q <= map0_d;
      map1_q <= map1_d;
      swing0_q <= swing0_d;
      swing1_q <= swing1_d;
    end
  end

  // ==========================================================================
  // Read data register; holds the last answer until the next read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= `SLLC_ZERO_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flops
  assign reg_rdata = rdata_q;

  // Forced power-down per physical lane
  assign physical_output_lane_zero_pwdn = pwdn_q[`SLLC_PWDN_L0_BIT];
  assign physical_output_lane_one_pwdn = pwdn_q[`SLLC_PWDN_L1_BIT];

  // Logical lane carried by each physical lane; codes 4 to 7 pass through undefined
  assign physical_output_lane_zero_src = map0_q[`SLLC_SEL_MSB:0];
  assign physical_output_lane_one_src = map1_q[`SLLC_SEL_MSB:0];

  // Drive swing code per physical lane
  assign physical_output_lane_zero_swing = swing0_q[`SLLC_SEL_MSB:0];
  assign physical_output_lane_one_swing = swing1_q[`SLLC_SEL_MSB:0];
endmodule // sllc_lane_config_regs

// File: verification/sllc_lane_config_regs_properties.sv
// Concurrent checks on the ports of the lane configuration register bank
`timescale 1ns/10ps
`include "sllc_regs.svh"
module sllc_lane_config_regs_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire sllc_pkg::sllc_link_params_t link_params,
  input wire logic physical_output_lane_zero_pwdn,
  input wire logic physical_output_lane_one_pwdn,
  input wire logic [2:0] physical_output_lane_zero_src,
  input wire logic [2:0] physical_output_lane_one_src,
  input wire logic [2:0] physical_output_lane_zero_swing,
  input wire logic [2:0] physical_output_lane_one_swing
);
  // ==========================================================================
  // Write effects and read data
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Decoded write strobes per offset, and the format read strobe
  wire logic wp = reg_wr && reg_addr == `SLLC_OFF_PWDN;
  wire logic wm0 = reg_wr && reg_addr == `SLLC_OFF_MAP0;
  wire logic wm1 = reg_wr && reg_addr == `SLLC_OFF_MAP1;
  wire logic ws0 = reg_wr && reg_addr == `SLLC_OFF_SWING0;
  wire logic ws1 = reg_wr && reg_addr == `SLLC_OFF_SWING1;
  wire logic rf = reg_rd && reg_addr == `SLLC_OFF_FORMAT;
  property p_pd0; wp |=> physical_output_lane_zero_pwdn == $past(reg_wdata[0]); endproperty
  a_pd0: assert property (p_pd0) else $error("lane zero power-down wrong");
  property p_pd1; wp |=> physical_output_lane_one_pwdn == $past(reg_wdata[2]); endproperty
  a_pd1: assert property (p_pd1) else $error("lane one power-down wrong");
  property p_src0; wm0 |=> physical_output_lane_zero_src == $past(reg_wdata[2:0]); endproperty
  a_src0: assert property (p_src0) else $error("lane zero source wrong");
  property p_src1; wm1 |=> physical_output_lane_one_src == $past(reg_wdata[2:0]); endproperty
  a_src1: assert property (p_src1) else $error("lane one source wrong");
  property p_sw0; ws0 |=> physical_output_lane_zero_swing == $past(reg_wdata[2:0]); endproperty
  a_sw0: assert property (p_sw0) else $error("lane zero swing wrong");
  property p_sw1; ws1 |=> physical_output_lane_one_swing == $past(reg_wdata[2:0]); endproperty
  a_sw1: assert property (p_sw1) else $error("lane one swing wrong");
  // Format byte lags the live parameters by one cycle, so they must be steady
  property p_fmt; !$past(rst) && rf && $stable(link_params) |=>
    reg_rdata == {$past(link_params.high_density_flag), 2'b00,
                  $past(link_params.control_words_per_frame)}; endproperty
  a_fmt: assert property (p_fmt) else $error("format byte wrong");
  property p_hold; !reg_rd |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  // Lane zero map read shows the routed lane, with bits 7 and 3 always clear
  property p_maprd; reg_rd && reg_addr == `SLLC_OFF_MAP0 |=> !reg_rdata[7] && !reg_rdata[3]
    && reg_rdata[2:0] == $past(physical_output_lane_zero_src); endproperty
  a_maprd: assert property (p_maprd) else $error("lane zero map read wrong");
  property p_swrd; reg_rd && reg_addr == `SLLC_OFF_SWING0 |=>
    reg_rdata == {5'h00, $past(physical_output_lane_zero_swing)}; endproperty
  a_swrd: assert property (p_swrd) else $error("lane zero swing read wrong");
endmodule // sllc_lane_config_regs_properties

bind sllc_lane_config_regs sllc_lane_config_regs_properties u_props (
  .clock(clock),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .link_params(link_params),
  .physical_output_lane_zero_pwdn(physical_output_lane_zero_pwdn),
  .physical_output_lane_one_pwdn(physical_output_lane_one_pwdn),
  .physical_output_lane_zero_src(physical_output_lane_zero_src),
  .physical_output_lane_one_src(physical_output_lane_one_src),
  .physical_output_lane_zero_swing(physical_output_lane_zero_swing),
  .physical_output_lane_one_swing(physical_output_lane_one_swing)
);

// File: verification/sllc_lane_config_regs_test.sv
// Self-checking bench for the lane configuration register bank
`timescale 1ns/10ps
`include "sllc_regs.svh"
module sllc_lane_config_regs_test;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  sllc_pkg::sllc_link_params_t link_params = '0;
  logic pd0, pd1;
  logic [2:0] s0, s1, w0, w1;
  int miscompares = 0;
  int check_count = 0;
  sllc_lane_config_regs dut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_params(link_params),
    .physical_output_lane_zero_pwdn(pd0), .physical_output_lane_one_pwdn(pd1),
    .physical_output_lane_zero_src(s0), .physical_output_lane_one_src(s1),
    .physical_output_lane_zero_swing(w0), .physical_output_lane_one_swing(w1));
  // 50 ns clock
  initial forever #25 clock = ~clock;
  // ==========================================================================
  // Helpers
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Strobes are one-cycle pulses launched on the falling edge
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("reg_rdata", e, reg_rdata);
  endtask
  // Expected checksum: all parameters plus lane id, wrapping at eight bits
  function automatic logic [7:0] cks(input logic [7:0] lid);
    sllc_pkg::sllc_link_params_t p;
    p = link_params;
    return p.did + p.bid + lid + p.l_m1 + p.scr + p.f_m1 + p.k_m1 + p.m_m1 + p.cs + p.n_m1
      + p.subclass + p.np_m1 + p.jesdv + p.s_m1 + p.high_density_flag
      + p.control_words_per_frame;
  endfunction
  task close_out;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short well beyond the expected run
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  // ==========================================================================
  // Main sequence; parameters chosen so the sum wraps past 256
  initial begin
    link_params.did = 8'hf0;
    link_params.f_m1 = 8'hd3;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    chk("pd0", 8'h00, {7'h00, pd0});
    chk("pd1", 8'h00, {7'h00, pd1});
    chk("src0", 8'h00, {5'h00, s0});
    chk("src1", 8'h01, {5'h00, s1});
    chk("swing0", 8'h01, {5'h00, w0});
    chk("swing1", 8'h01, {5'h00, w1});
    rd(`SLLC_OFF_CKSUM0, 8'hc3);
    rd(`SLLC_OFF_CKSUM1, 8'hc4);
    rd(`SLLC_OFF_PWDN, 8'hfa);
    rd(`SLLC_OFF_FORMAT, 8'h00);
    rd(`SLLC_OFF_MAP0, 8'h00);
    rd(`SLLC_OFF_MAP1, 8'h11);
    rd(`SLLC_OFF_SWING1, 8'h01);
    wr(`SLLC_OFF_PWDN, 8'hfb);
    chk("pd0", 8'h01, {7'h00, pd0});
    chk("pd1", 8'h00, {7'h00, pd1});
    wr(`SLLC_OFF_PWDN, 8'hfe);
    chk("pd0", 8'h00, {7'h00, pd0});
    chk("pd1", 8'h01, {7'h00, pd1});
    rd(`SLLC_OFF_PWDN, 8'hfe);
    wr(`SLLC_OFF_MAP0, 8'hff);
    rd(`SLLC_OFF_MAP0, 8'h77);
    chk("src0", 8'h07, {5'h00, s0});
    rd(`SLLC_OFF_CKSUM0, cks(8'h07));
    // Every documented lane code on lane one
    for (int i = 0; i < 4; i++) begin
      wr(`SLLC_OFF_MAP1, 8'(i));
      chk("src1", 8'(i), {5'h00, s1});
      rd(`SLLC_OFF_CKSUM1, cks(8'(i)));
    end
    wr(`SLLC_OFF_SWING0, 8'hf8);
    rd(`SLLC_OFF_SWING0, 8'h00);
    wr(`SLLC_OFF_SWING1, 8'h02);
    chk("swing1", 8'h02, {5'h00, w1});
    chk("swing0", 8'h00, {5'h00, w0});
    link_params.high_density_flag = 1'b1;
    link_params.control_words_per_frame = 5'h05;
    wr(`SLLC_OFF_FORMAT, 8'h00);
    rd(`SLLC_OFF_FORMAT, 8'h85);
    wr(`SLLC_OFF_CKSUM1, 8'h00);
    rd(`SLLC_OFF_CKSUM1, cks(8'h03));
    rd(16'h05b1, 8'h00);
    close_out();
  end
endmodule // sllc_lane_config_regs_test
